// ===== logic/dcs_regs.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Summary of operation
// - Bit 0 correctable reporting enable, RW, reset 0.
// - Bit 1 non-fatal reporting enable, RW, reset 0.
// - Bit 2 fatal reporting enable, RW, reset 0.
// - Bit 3 unsupported request enable, RW, reset 0.
// - Bit 4 relaxed ordering always reads zero.
// - Bits 7:5 payload size, RW, reset 000b.
// - Oversize payload write stores supported maximum.
// - Bits 8 and 9 always read zero.
// - Bit 10 aux power enable, sticky RW.
// - Bit 11 no-snoop enable reads zero.
// - Bits 14:12 read request size hardwired zero.
// - Bits 16..19 error flags, set, write-one-clear.
// - Flags set regardless of reporting enables.
// - Bit 20 aux power detected, RO, reset 1.
// - Bit 21 transactions pending hardwired zero.
// - Supported maximum resets from strap: 001b/010b.
module dcs_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sticky_resetn,
	input wire logic payload_size_strap,
	input wire logic aux_power_present,
	input wire dcs_pkg::dcs_err_s err_detect,
	input wire logic awvalid,
	output logic awready,
	input wire dcs_pkg::dcs_addr_s aw,
	input wire logic wvalid,
	output logic wready,
	input wire dcs_pkg::dcs_wdata_s w,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire dcs_pkg::dcs_addr_s ar,
	output logic rvalid,
	input wire logic rready,
	output dcs_pkg::dcs_rdata_s r,
	output logic [3:0] report_en,
	output logic [2:0] payload_size,
	output logic aux_pm_en
);
	import dcs_pkg::*;

	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	logic [3:0] report_en_q;
	logic [2:0] payload_q;
	logic aux_pm_en_q;
	logic [3:0] err_det_q;
	logic aux_det_q;
	logic [2:0] support_q;
	logic strap_q1;
	logic strap_q2;
	logic aux_q1;
	logic aux_q2;
	logic strap_load_q;

	// ----------------------------------------------------------------
	// Write channel.
	// ----------------------------------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] waddr_q;
	dcs_wdata_s wdata_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wr_fire;
	logic [31:0] wmask;
	logic [31:0] wval;

	// A write commits once both halves are held and no response is pending.
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign wval = wdata_q.data;

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------
	logic wr_hit_ctrl;
	logic wr_hit_support;
	logic wr_hit_sticky;
	logic wr_mapped;

	assign wr_hit_ctrl = waddr_q == DCS_OFF_CTRL_STAT;
	assign wr_hit_support = waddr_q == DCS_OFF_SUPPORT;
	assign wr_hit_sticky = waddr_q == DCS_OFF_AUX_STICKY;
	assign wr_mapped = wr_hit_ctrl || wr_hit_support || wr_hit_sticky;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wdata_q.strb[i]}};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			waddr_q <= 8'h00;
		end else if (awvalid && awready) begin
			aw_held_q <= 1'b1;
			waddr_q <= aw.addr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q <= '0;
		end else if (wvalid && wready) begin
			w_held_q <= 1'b1;
			wdata_q <= w;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= DCS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? DCS_RESP_OKAY : DCS_RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Ready is registered: it drops once an item is held and stays low until the
	// response has been taken, so that only one write is under way.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
		end else begin
			awready <= !(aw_held_q || (awvalid && awready)) && !wr_fire &&
				!(bvalid_q && !bready);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b0;
		end else begin
			wready <= !(w_held_q || (wvalid && wready)) && !wr_fire &&
				!(bvalid_q && !bready);
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	logic wr_ctrl;
	assign wr_ctrl = wr_fire && wr_hit_ctrl;

	// ----------------------------------------------------------------
	// Strap and presence synchronisers.
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		strap_q1 <= payload_size_strap;
		strap_q2 <= strap_q1;
		aux_q1 <= aux_power_present;
		aux_q2 <= aux_q1;
	end

	// The supported maximum is loaded from the strap in the first cycle after reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_load_q <= 1'b1;
			support_q <= DCS_SUPPORT_STRAP_LO;
		end else if (strap_load_q) begin
			strap_load_q <= 1'b0;
			support_q <= strap_q2 ? DCS_SUPPORT_STRAP_HI : DCS_SUPPORT_STRAP_LO;
		end else if (wr_fire && wr_hit_support && wdata_q.strb[0]) begin
			support_q <= wval[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Payload clamp.
	// ----------------------------------------------------------------
	logic [2:0] payload_wr;
	logic [2:0] payload_clamped;

	assign payload_wr = wval[DCS_PAYLOAD_LSB +: 3];
	// A code above the supported maximum is replaced by the maximum itself.
	assign payload_clamped = (payload_wr > support_q) ? support_q : payload_wr;

	// ----------------------------------------------------------------
	// Control fields.
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			report_en_q <= DCS_RST_REPORT_EN;
		end else if (wr_ctrl) begin
			for (int i = 0; i < 4; i++) begin
				if (wmask[DCS_CORR_EN_BIT + i]) begin
					report_en_q[i] <= wval[DCS_CORR_EN_BIT + i];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			payload_q <= DCS_RST_PAYLOAD;
		end else if (wr_ctrl && wmask[DCS_PAYLOAD_LSB]) begin
			payload_q <= payload_clamped;
		end
	end

	// Only the auxiliary power domain reset clears this bit.
	always_ff @(posedge aclk) begin
		if (!sticky_resetn) begin
			aux_pm_en_q <= DCS_RST_AUX_PM_EN;
		end else if (wr_ctrl && wmask[DCS_AUX_PM_EN_BIT]) begin
			aux_pm_en_q <= wval[DCS_AUX_PM_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Status fields.
	// ----------------------------------------------------------------
	logic [3:0] err_clr;
	// A one written in the lane-2 byte clears the matching flag.
	assign err_clr = (wr_ctrl && wmask[DCS_ERR_DET_LSB]) ? wval[DCS_ERR_DET_LSB +: 4] : 4'h0;

	// A detection in the cycle of a clear wins, so no new error is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_det_q <= DCS_RST_ERR_DET;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (err_detect[k]) begin
					err_det_q[k] <= 1'b1;
				end else if (err_clr[k]) begin
					err_det_q[k] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_det_q <= DCS_RST_AUX_DET;
		end else begin
			aux_det_q <= aux_q2;
		end
	end

	// ----------------------------------------------------------------
	// Read channel.
	// ----------------------------------------------------------------
	logic [31:0] ctrl_stat_word;

	// Hardwired and reserved bits are left at zero.
	always_comb begin
		ctrl_stat_word = 32'h0000_0000;
		ctrl_stat_word[DCS_CORR_EN_BIT +: 4] = report_en_q;
		ctrl_stat_word[DCS_PAYLOAD_LSB +: 3] = payload_q;
		ctrl_stat_word[DCS_AUX_PM_EN_BIT] = aux_pm_en_q;
		ctrl_stat_word[DCS_ERR_DET_LSB +: 4] = err_det_q;
		ctrl_stat_word[DCS_AUX_DET_BIT] = aux_det_q;
	end

	// ----------------------------------------------------------------
	// Read data select.
	// ----------------------------------------------------------------
	dcs_rdata_s rd_next;

	// Unmapped offsets answer with an error and all-zero data.
	always_comb begin
		rd_next = '{data: 32'h0000_0000, resp: DCS_RESP_SLVERR};
		case (ar.addr)
			DCS_OFF_CTRL_STAT: begin
				rd_next = '{data: ctrl_stat_word, resp: DCS_RESP_OKAY};
			end
			DCS_OFF_SUPPORT: begin
				rd_next = '{data: {29'h0, support_q}, resp: DCS_RESP_OKAY};
			end
			DCS_OFF_AUX_STICKY: begin
				rd_next = '{data: {31'h0, aux_pm_en_q}, resp: DCS_RESP_OKAY};
			end
			default: begin
				rd_next = '{data: 32'h0000_0000, resp: DCS_RESP_SLVERR};
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			r <= '0;
		end else if (rvalid) begin
			if (rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			r <= rd_next;
		end else begin
			arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Outputs to the port logic.
	// ----------------------------------------------------------------
	// Copies for the port logic lag the registers by one cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			report_en <= DCS_RST_REPORT_EN;
		end else begin
			report_en <= report_en_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			payload_size <= DCS_RST_PAYLOAD;
		end else begin
			payload_size <= payload_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_pm_en <= DCS_RST_AUX_PM_EN;
		end else begin
			aux_pm_en <= aux_pm_en_q;
		end
	end

endmodule : dcs_regs

// ===== logic/dcs_pkg.sv
package dcs_pkg;

	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	localparam logic [7:0] DCS_OFF_CTRL_STAT = 8'hc8;
	localparam logic [7:0] DCS_OFF_SUPPORT = 8'hcc;
	localparam logic [7:0] DCS_OFF_AUX_STICKY = 8'hd0;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int DCS_CORR_EN_BIT = 0;
	localparam int DCS_NONFATAL_EN_BIT = 1;
	localparam int DCS_FATAL_EN_BIT = 2;
	localparam int DCS_UNSUP_EN_BIT = 3;
	localparam int DCS_PAYLOAD_LSB = 5;
	localparam int DCS_AUX_PM_EN_BIT = 10;
	localparam int DCS_ERR_DET_LSB = 16;
	localparam int DCS_AUX_DET_BIT = 20;

	// ----------------------------------------------------------------
	// Reset values.
	// ----------------------------------------------------------------
	localparam logic [3:0] DCS_RST_REPORT_EN = 4'h0;
	localparam logic [2:0] DCS_RST_PAYLOAD = 3'h0;
	localparam logic DCS_RST_AUX_PM_EN = 1'b0;
	localparam logic [3:0] DCS_RST_ERR_DET = 4'h0;
	localparam logic DCS_RST_AUX_DET = 1'b1;
	localparam logic [2:0] DCS_SUPPORT_STRAP_LO = 3'h1;
	localparam logic [2:0] DCS_SUPPORT_STRAP_HI = 3'h2;

	// ----------------------------------------------------------------
	// AXI4-Lite responses and channel carriers.
	// ----------------------------------------------------------------
	localparam logic [1:0] DCS_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCS_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] prot;
	} dcs_addr_s;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] strb;
	} dcs_wdata_s;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} dcs_rdata_s;

	// One-cycle error detection pulses from the port's receive logic.
	typedef struct packed {
		logic unsup;
		logic fatal;
		logic nonfatal;
		logic corr;
	} dcs_err_s;

endpackage : dcs_pkg

// ===== verif/dcs_regs_asserts.sv
`timescale 1ns/1ps
module dcs_regs_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire dcs_pkg::dcs_addr_s ar,
	input wire logic rvalid,
	input wire logic rready,
	input wire dcs_pkg::dcs_rdata_s r,
	input wire logic [3:0] report_en,
	input wire logic [2:0] payload_size,
	input wire logic aux_pm_en
);
	import dcs_pkg::*;
	logic [7:0] ra_q;
	// ----------
	// Address of the read in flight.
	// ----------
	always_ff @(posedge aclk) begin
		if (arvalid && arready) begin
			ra_q <= ar.addr;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_RSVD_ZERO: assert property (rvalid && ra_q == DCS_OFF_CTRL_STAT
		|-> (r.data & 32'hffe0fb10) == 32'h0) else $error("fixed bits set");
	AST_MIRROR: assert property (rvalid && ra_q == DCS_OFF_CTRL_STAT
		|-> r.data[3:0] == report_en && r.data[7:5] == payload_size
		&& r.data[10] == aux_pm_en) else $error("mirror differs");
	AST_RST_VAL: assert property ($rose(aresetn)
		|-> report_en == 4'h0 && payload_size == 3'h0) else $error("reset value");
	AST_RLAT: assert property (arvalid && arready |=> rvalid) else $error("late read");
	AST_RHOLD: assert property (rvalid && !rready |=> rvalid && $stable(r))
		else $error("read dropped");
	AST_BHOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("resp dropped");
	AST_BBUSY: assert property (bvalid |-> !awready && !wready) else $error("ready early");
	AST_RBUSY: assert property (rvalid |-> !arready) else $error("arready early");
	AST_SLVERR: assert property (rvalid && r.resp == DCS_RESP_SLVERR
		|-> r.data == 32'h0) else $error("error data");
endmodule : dcs_regs_asserts
bind dcs_regs dcs_regs_asserts u_ast (.*);

// ===== verif/dcs_regs_tb_top.sv
`timescale 1ns/1ps
module dcs_regs_tb_top;
	import dcs_pkg::*;
	logic aclk, aresetn, sticky_resetn, payload_size_strap, aux_power_present;
	dcs_err_s err_detect;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, aux_pm_en, auxen, aux;
	dcs_addr_s aw, ar;
	dcs_wdata_s w;
	dcs_rdata_s r;
	logic [1:0] bresp, rd_r;
	logic [3:0] report_en, ren, flg;
	logic [2:0] payload_size, pay, sup;
	logic [31:0] rd_d, d, x;
	int err_count, checks, seed, i;
	dcs_regs uut (.*);
	// ----------
	// Bus tasks and model.
	// ----------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		arvalid <= 1'b1;
		ar <= '{a, 3'h0};
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (n > 1) rready <= 1'b1;
		end
		if (n == 50) err_count++;
		rd_d = r.data;
		rd_r = r.resp;
		rready <= 1'b0;
		chk({30'h0, rd_r}, {30'h0, er});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s,
		input logic [3:0] e);
		logic [1:0] br;
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw <= '{a, 3'h0};
		w <= '{dd, s};
		err_detect <= e;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (n > 1) bready <= 1'b1;
		end
		if (n == 50) err_count++;
		br = bresp;
		bready <= 1'b0;
		err_detect <= 4'h0;
		chk({30'h0, br}, {30'h0, (a == 8'h40) ? DCS_RESP_SLVERR : DCS_RESP_OKAY});
		if (a == DCS_OFF_CTRL_STAT) begin
			if (s[0]) ren = dd[3:0];
			if (s[0]) pay = (dd[7:5] > sup) ? sup : dd[7:5];
			if (s[1]) auxen = dd[10];
			if (s[2]) flg = flg & ~dd[19:16];
		end
		flg = flg | e;
	endtask : wr
	task automatic rst(input logic st);
		aresetn <= 1'b0;
		sticky_resetn <= st;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		sticky_resetn <= 1'b1;
		ren = 4'h0;
		pay = 3'h0;
		flg = 4'h0;
		if (!st) auxen = 1'b0;
		sup = payload_size_strap ? DCS_SUPPORT_STRAP_HI : DCS_SUPPORT_STRAP_LO;
	endtask : rst
	task automatic rdc8;
		rd(DCS_OFF_CTRL_STAT, DCS_RESP_OKAY);
		x = {10'h0, 1'b0, aux, flg, 5'h0, auxen, 2'h0, pay, 1'b0, ren};
		chk(rd_d & 32'hffff, x & 32'hffff);
		chk(rd_d >> 16, x >> 16);
		chk({aux_pm_en, payload_size, report_en}, {auxen, pay, ren});
	endtask : rdc8
	task automatic end_sim;
		if (err_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		#100000;
		err_count++;
		end_sim();
	end
	initial begin
		seed = 32'h6669;
		{payload_size_strap, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{aw, ar, w, err_detect} = '0;
		aux_power_present = 1'b1;
		aux = 1'b1;
		auxen = 1'b0;
		rst(1'b0);
		rdc8();
		rd(DCS_OFF_SUPPORT, DCS_RESP_OKAY);
		chk(rd_d, {29'h0, sup});
		rd(8'h40, DCS_RESP_SLVERR);
		chk(rd_d, 32'h0);
		for (i = 0; i < 40; i++) begin
			d = $random(seed);
			aux_power_present <= d[0];
			aux = d[0];
			if (i == 20) wr(DCS_OFF_SUPPORT, 32'h3, 4'hf, 4'h0);
			if (i == 20) sup = 3'h3;
			wr((d[2:1] == 2'h0) ? 8'h40 : DCS_OFF_CTRL_STAT, $random(seed), d[7:4], d[11:8]);
			rdc8();
		end
		payload_size_strap <= 1'b1;
		wr(DCS_OFF_CTRL_STAT, 32'h400, 4'h2, 4'h0);
		rst(1'b1);
		rdc8();
		rd(DCS_OFF_SUPPORT, DCS_RESP_OKAY);
		chk(rd_d, {29'h0, sup});
		rst(1'b0);
		rdc8();
		end_sim();
	end
endmodule : dcs_regs_tb_top
